// >>> sacf_pkg.sv
// package: constants and types for the serial addressed command front end
package sacf_pkg;
   // clock and serial timing
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_DEF = 9600;
   localparam int BIT_CYCLES_DEF = (CLK_HZ + BAUD_DEF / 2) / BAUD_DEF;
   localparam logic [15:0] BAUD_MIN = 16'h0010;
   // register map
   localparam int APB_AW = 12;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_ADDR = 12'h004;
   localparam logic [11:0] OFF_BAUD = 12'h008;
   localparam logic [11:0] OFF_STATUS = 12'h00c;
   // field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PAR_EN_BIT = 2;
   localparam int CTRL_PAR_ODD_BIT = 3;
   localparam int CTRL_DATA7_BIT = 4;
   localparam int CTRL_STOP2_BIT = 5;
   localparam int STAT_DROP_LSB = 8;
   // reset values, address limit and stop-bit codes
   localparam logic [7:0] ADDR_DEF = 8'h04;
   localparam logic [7:0] ADDR_MAX = 8'h0f;
   localparam logic PAR_EN_DEF = 1'b0;
   localparam logic PAR_ODD_DEF = 1'b0;
   localparam logic DATA7_DEF = 1'b0;
   localparam logic [1:0] STOP_ONE = 2'h1;
   localparam logic [1:0] STOP_TWO = 2'h2;
   // characters, and ten for splitting the address into digits
   localparam logic [7:0] CH_STX = 8'h02;
   localparam logic [7:0] CH_ETX = 8'h03;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_QM = 8'h3f;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_1 = 8'h31;
   localparam logic [7:0] ADDR_TENS = 8'h0a;

   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_ADDR = 2'b01,
      MODE_PKT = 2'b10
   } sacf_mode_type;

   typedef enum logic [2:0] {
      PS_IDLE = 3'b000,
      PS_PFX2 = 3'b001,
      PS_CMD = 3'b010,
      PS_SKIP = 3'b011,
      PS_PADDR = 3'b100,
      PS_PMSG = 3'b101,
      PS_PSUM = 3'b110
   } sacf_ps_type;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } sacf_rx_type;

   typedef struct packed {
      logic par_en;
      logic par_odd;
      logic data7;
      logic [1:0] stop_bit_count;
      logic [15:0] bit_cycles;
   } sacf_ser_cfg_type;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic done;
      logic abort;
      logic reply;
   } sacf_cmd_type;
endpackage

// >>> sacf_uart_rx.sv
// module: asynchronous character receiver with selectable format
`timescale 1ns/1ps
module sacf_uart_rx (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // line and format
   input wire logic rxd_i,
   input wire logic [15:0] bit_cycles_i,
   input wire logic data7_i,
   input wire logic par_en_i,
   input wire logic par_odd_i,
   // received character
   output logic [7:0] byte_o,
   output logic vld_o,
   output logic err_o
);
   sacf_pkg::sacf_rx_type st_r, st_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic par_r, par_nxt;
   logic [7:0] byte_nxt;
   logic vld_nxt, err_nxt;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r - 16'h0001;
      idx_nxt = idx_r;
      sh_nxt = sh_r;
      par_nxt = par_r;
      byte_nxt = byte_o;
      vld_nxt = 1'b0;
      err_nxt = 1'b0;
      case (st_r)
         sacf_pkg::RX_IDLE: begin
            // sample mid-bit: wait half a bit after the falling edge
            cnt_nxt = {1'b0, bit_cycles_i[15:1]};
            if (!rxd_i) begin
               st_nxt = sacf_pkg::RX_START;
            end
         end
         sacf_pkg::RX_START: begin
            if (cnt_r == 16'h0000) begin
               cnt_nxt = bit_cycles_i - 16'h0001;
               idx_nxt = 3'h0;
               par_nxt = par_odd_i;
               // a glitch shorter than half a bit is not a start
               st_nxt = rxd_i ? sacf_pkg::RX_IDLE : sacf_pkg::RX_DATA;
            end
         end
         sacf_pkg::RX_DATA: begin
            if (cnt_r == 16'h0000) begin
               cnt_nxt = bit_cycles_i - 16'h0001;
               sh_nxt = {rxd_i, sh_r[7:1]};
               par_nxt = par_r ^ rxd_i;
               idx_nxt = idx_r + 3'h1;
               if (idx_r == (data7_i ? 3'h6 : 3'h7)) begin
                  st_nxt = par_en_i ? sacf_pkg::RX_PAR : sacf_pkg::RX_STOP;
               end
            end
         end
         sacf_pkg::RX_PAR: begin
            if (cnt_r == 16'h0000) begin
               cnt_nxt = bit_cycles_i - 16'h0001;
               par_nxt = par_r ^ rxd_i;
               st_nxt = sacf_pkg::RX_STOP;
            end
         end
         sacf_pkg::RX_STOP: begin
            // only the first stop bit is checked; a second one is idle level
            if (cnt_r == 16'h0000) begin
               st_nxt = sacf_pkg::RX_IDLE;
               vld_nxt = 1'b1;
               byte_nxt = data7_i ? {1'b0, sh_r[7:1]} : sh_r;
               err_nxt = !rxd_i || (par_en_i && par_r);
            end
         end
         default: begin
            st_nxt = sacf_pkg::RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= sacf_pkg::RX_IDLE;
         cnt_r <= 16'h0000;
         idx_r <= 3'h0;
         sh_r <= 8'h00;
         par_r <= 1'b0;
         byte_o <= 8'h00;
         vld_o <= 1'b0;
         err_o <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         idx_r <= idx_nxt;
         sh_r <= sh_nxt;
         par_r <= par_nxt;
         byte_o <= byte_nxt;
         vld_o <= vld_nxt;
         err_o <= err_nxt;
      end
   end
endmodule // sacf_uart_rx

// >>> sacf_frontend.sv
// module: receive-side command front end with apb configuration
//
// Contract
// - addressed mode accepts only matching two-char prefix
// - device address limited to zero through fifteen
// - addressed mode replies to queries only
// - packet mode ignores packets for other addresses
// - packet mode replies to every accepted packet
// - packet is stx, address, message, etx, checksum
// - mode defaults off, address defaults four
// - default 9600 8n1, parity/7 bits/2 stops selectable
// - off mode is plain async, queries answered
// - half duplex, reply only after received command
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module sacf_frontend #(
   parameter logic [15:0] BIT_CYCLES = 16'(sacf_pkg::BIT_CYCLES_DEF)
) (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [sacf_pkg::APB_AW-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // serial line and configuration for the transmitter
   input wire logic RXD_I,
   output sacf_pkg::sacf_ser_cfg_type SER_CFG_O,
   // command stream toward the interpreter
   output sacf_pkg::sacf_cmd_type CMD_O
);
   sacf_pkg::sacf_mode_type mode_r, mode_nxt;
   sacf_pkg::sacf_ser_cfg_type cfg_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [31:0] prdata_nxt;
   logic pready_nxt, pslverr_nxt, ctrl_wr;
   sacf_pkg::sacf_ps_type ps_r, ps_nxt;
   sacf_pkg::sacf_cmd_type cmd_nxt;
   logic [7:0] sum_r, sum_nxt, hi_r, hi_nxt, drop_r, drop_nxt, exp_hi, exp_lo;
   logic query_r, query_nxt, fwd, cmd_phase, rx_ok;
   logic [7:0] rx_byte;
   logic rx_vld, rx_err;

   sacf_uart_rx u_rx (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .rxd_i(RXD_I),
      .bit_cycles_i(SER_CFG_O.bit_cycles),
      .data7_i(SER_CFG_O.data7),
      .par_en_i(SER_CFG_O.par_en),
      .par_odd_i(SER_CFG_O.par_odd),
      .byte_o(rx_byte),
      .vld_o(rx_vld),
      .err_o(rx_err)
   );

   // apb: decide in the first access cycle, commit at the pready edge
   always_comb begin
      pready_nxt = 1'b0;
      pslverr_nxt = PSLVERR_O;
      prdata_nxt = PRDATA_O;
      mode_nxt = mode_r;
      cfg_nxt = SER_CFG_O;
      addr_nxt = addr_r;
      ctrl_wr = 1'b0;
      if (PSEL_I && PENABLE_I && !PREADY_O) begin
         pready_nxt = 1'b1;
         pslverr_nxt = 1'b0;
         prdata_nxt = 32'h0000_0000;
         if (PADDR_I == sacf_pkg::OFF_CTRL) begin
            prdata_nxt[sacf_pkg::CTRL_MODE_LSB +: 2] = mode_r;
            prdata_nxt[sacf_pkg::CTRL_PAR_EN_BIT] = SER_CFG_O.par_en;
            prdata_nxt[sacf_pkg::CTRL_PAR_ODD_BIT] = SER_CFG_O.par_odd;
            prdata_nxt[sacf_pkg::CTRL_DATA7_BIT] = SER_CFG_O.data7;
            prdata_nxt[sacf_pkg::CTRL_STOP2_BIT] = SER_CFG_O.stop_bit_count == sacf_pkg::STOP_TWO;
            pslverr_nxt = PWRITE_I && (PWDATA_I[sacf_pkg::CTRL_MODE_LSB +: 2] == 2'b11);
         end else if (PADDR_I == sacf_pkg::OFF_ADDR) begin
            prdata_nxt[7:0] = addr_r;
            pslverr_nxt = PWRITE_I && (PWDATA_I > 32'(sacf_pkg::ADDR_MAX));
         end else if (PADDR_I == sacf_pkg::OFF_BAUD) begin
            prdata_nxt[15:0] = SER_CFG_O.bit_cycles;
            pslverr_nxt = PWRITE_I && (PWDATA_I[15:0] < sacf_pkg::BAUD_MIN);
         end else if (PADDR_I == sacf_pkg::OFF_STATUS) begin
            prdata_nxt[2:0] = ps_r;
            prdata_nxt[sacf_pkg::STAT_DROP_LSB +: 8] = drop_r;
            pslverr_nxt = PWRITE_I;
         end else begin
            pslverr_nxt = 1'b1;
         end
      end
      if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O) begin
         if (PADDR_I == sacf_pkg::OFF_CTRL) begin
            ctrl_wr = 1'b1;
            mode_nxt = sacf_pkg::sacf_mode_type'(PWDATA_I[sacf_pkg::CTRL_MODE_LSB +: 2]);
            cfg_nxt.par_en = PWDATA_I[sacf_pkg::CTRL_PAR_EN_BIT];
            cfg_nxt.par_odd = PWDATA_I[sacf_pkg::CTRL_PAR_ODD_BIT];
            cfg_nxt.data7 = PWDATA_I[sacf_pkg::CTRL_DATA7_BIT];
            cfg_nxt.stop_bit_count = PWDATA_I[sacf_pkg::CTRL_STOP2_BIT] ?
               sacf_pkg::STOP_TWO : sacf_pkg::STOP_ONE;
         end else if (PADDR_I == sacf_pkg::OFF_ADDR) begin
            addr_nxt = PWDATA_I[7:0];
         end else if (PADDR_I == sacf_pkg::OFF_BAUD) begin
            cfg_nxt.bit_cycles = PWDATA_I[15:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
         mode_r <= sacf_pkg::MODE_OFF;
         addr_r <= sacf_pkg::ADDR_DEF;
         SER_CFG_O <= {sacf_pkg::PAR_EN_DEF, sacf_pkg::PAR_ODD_DEF, sacf_pkg::DATA7_DEF,
                       sacf_pkg::STOP_ONE, BIT_CYCLES};
      end else begin
         PREADY_O <= pready_nxt;
         PSLVERR_O <= pslverr_nxt;
         PRDATA_O <= prdata_nxt;
         mode_r <= mode_nxt;
         addr_r <= addr_nxt;
         SER_CFG_O <= cfg_nxt;
      end
   end

   // expected prefix: two decimal digits of the address
   always_comb begin
      exp_hi = (addr_r >= sacf_pkg::ADDR_TENS) ? sacf_pkg::CH_1 : sacf_pkg::CH_0;
      exp_lo = sacf_pkg::CH_0 + ((addr_r >= sacf_pkg::ADDR_TENS) ?
                                 (addr_r - sacf_pkg::ADDR_TENS) : addr_r);
   end

   assign fwd = (ps_r == sacf_pkg::PS_CMD) || (ps_r == sacf_pkg::PS_PMSG) ||
                (ps_r == sacf_pkg::PS_PSUM);
   assign cmd_phase = (ps_r == sacf_pkg::PS_CMD) ||
                      (ps_r == sacf_pkg::PS_IDLE && mode_r == sacf_pkg::MODE_OFF);
   assign rx_ok = rx_vld && !rx_err && !ctrl_wr;

   // bytes are forwarded as they come; the interpreter commits on done
   // and discards on abort, so no packet buffer is needed
   always_comb begin
      ps_nxt = ps_r;
      sum_nxt = sum_r;
      hi_nxt = hi_r;
      query_nxt = query_r;
      drop_nxt = drop_r;
      cmd_nxt = '0;
      cmd_nxt.data = CMD_O.data;
      if (ctrl_wr) begin
         ps_nxt = sacf_pkg::PS_IDLE;
         query_nxt = 1'b0;
         cmd_nxt.abort = fwd;
      end else if (rx_vld && rx_err) begin
         cmd_nxt.abort = fwd;
         query_nxt = 1'b0;
         ps_nxt = (mode_r == sacf_pkg::MODE_PKT) ? sacf_pkg::PS_IDLE : sacf_pkg::PS_SKIP;
      end else if (rx_vld && mode_r == sacf_pkg::MODE_PKT && rx_byte == sacf_pkg::CH_STX) begin
         cmd_nxt.abort = fwd;
         ps_nxt = sacf_pkg::PS_PADDR;
      end else if (rx_vld && cmd_phase) begin
         if (rx_byte == sacf_pkg::CH_LF) begin
            cmd_nxt.done = 1'b1;
            cmd_nxt.reply = query_r;
            query_nxt = 1'b0;
            ps_nxt = sacf_pkg::PS_IDLE;
         end else begin
            cmd_nxt.valid = 1'b1;
            cmd_nxt.data = rx_byte;
            query_nxt = query_r || (rx_byte == sacf_pkg::CH_QM);
            ps_nxt = sacf_pkg::PS_CMD;
         end
      end else if (rx_vld) begin
         case (ps_r)
            sacf_pkg::PS_IDLE: begin
               if (mode_r == sacf_pkg::MODE_ADDR) begin
                  hi_nxt = rx_byte;
                  ps_nxt = sacf_pkg::PS_PFX2;
               end
            end
            sacf_pkg::PS_PFX2: begin
               query_nxt = 1'b0;
               ps_nxt = (hi_r == exp_hi && rx_byte == exp_lo) ?
                        sacf_pkg::PS_CMD : sacf_pkg::PS_SKIP;
            end
            sacf_pkg::PS_SKIP: begin
               if (rx_byte == sacf_pkg::CH_LF) begin
                  ps_nxt = sacf_pkg::PS_IDLE;
               end
            end
            sacf_pkg::PS_PADDR: begin
               sum_nxt = rx_byte;
               ps_nxt = (rx_byte == addr_r) ? sacf_pkg::PS_PMSG : sacf_pkg::PS_IDLE;
            end
            sacf_pkg::PS_PMSG: begin
               sum_nxt = sum_r ^ rx_byte;
               if (rx_byte == sacf_pkg::CH_ETX) begin
                  ps_nxt = sacf_pkg::PS_PSUM;
               end else begin
                  cmd_nxt.valid = 1'b1;
                  cmd_nxt.data = rx_byte;
               end
            end
            sacf_pkg::PS_PSUM: begin
               ps_nxt = sacf_pkg::PS_IDLE;
               if (rx_byte == sum_r) begin
                  cmd_nxt.done = 1'b1;
                  cmd_nxt.reply = 1'b1;
               end else begin
                  cmd_nxt.abort = 1'b1;
                  drop_nxt = drop_r + 8'h01;
               end
            end
            default: begin
               ps_nxt = sacf_pkg::PS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         ps_r <= sacf_pkg::PS_IDLE;
         sum_r <= 8'h00;
         hi_r <= 8'h00;
         query_r <= 1'b0;
         drop_r <= 8'h00;
         CMD_O <= '0;
      end else begin
         ps_r <= ps_nxt;
         sum_r <= sum_nxt;
         hi_r <= hi_nxt;
         query_r <= query_nxt;
         drop_r <= drop_nxt;
         CMD_O <= cmd_nxt;
      end
   end

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   sequence s_psum;
      rx_ok && mode_r == sacf_pkg::MODE_PKT && ps_r == sacf_pkg::PS_PSUM &&
      rx_byte != sacf_pkg::CH_STX;
   endsequence
   sequence s_sum_ok;
      s_psum and (rx_byte == sum_r);
   endsequence
   sequence s_sum_bad;
      s_psum and (rx_byte != sum_r);
   endsequence

   property p_pfx_miss;
      rx_ok && ps_r == sacf_pkg::PS_PFX2 && mode_r == sacf_pkg::MODE_ADDR &&
      (hi_r != exp_hi || rx_byte != exp_lo) |=> ps_r == sacf_pkg::PS_SKIP && !CMD_O.valid;
   endproperty
   a_pfx_miss: assert property (p_pfx_miss) else $error("prefix mismatch accepted");
   property p_addr_range;
      addr_r <= sacf_pkg::ADDR_MAX;
   endproperty
   a_addr_range: assert property (p_addr_range) else $error("address above fifteen");
   property p_addr_quiet;
      rx_ok && mode_r == sacf_pkg::MODE_ADDR && ps_r == sacf_pkg::PS_CMD &&
      rx_byte == sacf_pkg::CH_LF |=> CMD_O.done && (CMD_O.reply == $past(query_r));
   endproperty
   a_addr_quiet: assert property (p_addr_quiet) else $error("addressed reply wrong");
   property p_pkt_other;
      rx_ok && mode_r == sacf_pkg::MODE_PKT && ps_r == sacf_pkg::PS_PADDR &&
      rx_byte != addr_r && rx_byte != sacf_pkg::CH_STX
      |=> ps_r == sacf_pkg::PS_IDLE ##1 !CMD_O.valid;
   endproperty
   a_pkt_other: assert property (p_pkt_other) else $error("foreign packet accepted");
   property p_pkt_reply;
      s_sum_ok |=> CMD_O.done && CMD_O.reply && !CMD_O.abort;
   endproperty
   a_pkt_reply: assert property (p_pkt_reply) else $error("packet not replied");
   property p_etx;
      rx_ok && mode_r == sacf_pkg::MODE_PKT && ps_r == sacf_pkg::PS_PMSG &&
      rx_byte == sacf_pkg::CH_ETX |=> ps_r == sacf_pkg::PS_PSUM && !CMD_O.valid;
   endproperty
   a_etx: assert property (p_etx) else $error("etx not followed by checksum");
   property p_rst_def;
      $fell(RST_I) |-> mode_r == sacf_pkg::MODE_OFF && addr_r == sacf_pkg::ADDR_DEF;
   endproperty
   a_rst_def: assert property (p_rst_def) else $error("mode or address default wrong");
   property p_fmt_def;
      $fell(RST_I) |-> SER_CFG_O.bit_cycles == BIT_CYCLES && !SER_CFG_O.par_en &&
      !SER_CFG_O.data7 && SER_CFG_O.stop_bit_count == sacf_pkg::STOP_ONE;
   endproperty
   a_fmt_def: assert property (p_fmt_def) else $error("serial format default wrong");
   property p_off_query;
      rx_ok && mode_r == sacf_pkg::MODE_OFF && cmd_phase && rx_byte == sacf_pkg::CH_LF
      |=> CMD_O.done && (CMD_O.reply == $past(query_r));
   endproperty
   a_off_query: assert property (p_off_query) else $error("async reply wrong");
   property p_reply_after;
      CMD_O.reply |-> CMD_O.done && $past(rx_vld);
   endproperty
   a_reply_after: assert property (p_reply_after) else $error("reply without command");
   property p_bad_sum;
      s_sum_bad |=> CMD_O.abort && !CMD_O.done && !CMD_O.reply &&
      drop_r == $past(drop_r) + 8'h01;
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("bad checksum not dropped");
   property p_stx;
      rx_ok && mode_r == sacf_pkg::MODE_PKT && rx_byte == sacf_pkg::CH_STX
      |=> ps_r == sacf_pkg::PS_PADDR;
   endproperty
   a_stx: assert property (p_stx) else $error("stx did not restart packet");
endmodule // sacf_frontend

// >>> sacf_host_model.sv
// host computer model: sends characters on the shared serial line
`timescale 1ns/1ps
module sacf_host_model (
   // clock
   input wire logic clk_i,
   // character format shared with the device
   input wire sacf_pkg::sacf_ser_cfg_type cfg_i,
   // serial line toward the device
   output logic rxd_o
);
   // pull-up on the line: idle high between characters
   initial rxd_o = 1'b1;

   task automatic send_bit(input logic v);
      rxd_o <= v;
      repeat (int'(cfg_i.bit_cycles)) @(posedge clk_i);
   endtask

   task automatic send_byte(input logic [7:0] b);
      int nb;
      logic p;
      nb = cfg_i.data7 ? 7 : 8;
      p = cfg_i.par_odd;
      for (int i = 0; i < nb; i++) p = p ^ b[i];
      @(posedge clk_i);
      send_bit(1'b0);
      for (int i = 0; i < nb; i++) send_bit(b[i]);
      if (cfg_i.par_en) send_bit(p);
      send_bit(1'b1);
      if (cfg_i.stop_bit_count == sacf_pkg::STOP_TWO) send_bit(1'b1);
   endtask

   // line held low through the stop bit of an 8n1 character, then idle again
   task automatic send_break();
      @(posedge clk_i);
      repeat (10) send_bit(1'b0);
      repeat (2) send_bit(1'b1);
   endtask

   // whole command or packet, one character after another with no wait at the end
   task automatic send_frame(input logic [7:0] q[$]);
      foreach (q[i]) send_byte(q[i]);
   endtask
endmodule // sacf_host_model

// >>> serial_addressed_command_frontend_bench.sv
// self-checking bench for the serial command front end
`timescale 1ns/1ps
module serial_addressed_command_frontend_bench;
   localparam logic [15:0] BITC = 16'h0010;
   logic CLK_SYS_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, RXD_I;
   logic [11:0] PADDR_I;
   logic [31:0] PWDATA_I, PRDATA_O, rd;
   logic err;
   sacf_pkg::sacf_ser_cfg_type SER_CFG_O;
   sacf_pkg::sacf_cmd_type CMD_O;
   int n_errors = 0;
   int comparisons = 0;
   int n_valid, n_done, n_reply, n_abort;
   logic [7:0] last_data;

   sacf_frontend #(.BIT_CYCLES(BITC)) i_dut (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
      .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
      .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
      .PSLVERR_O(PSLVERR_O), .RXD_I(RXD_I), .SER_CFG_O(SER_CFG_O), .CMD_O(CMD_O));
   sacf_host_model i_host (.clk_i(CLK_SYS_I), .cfg_i(SER_CFG_O), .rxd_o(RXD_I));

   initial begin
      CLK_SYS_I = 1'b0;
      forever #5 CLK_SYS_I = ~CLK_SYS_I;
   end

   // pulse counters on the command stream
   always @(posedge CLK_SYS_I) begin
      if (CMD_O.valid === 1'b1) begin
         n_valid++;
         last_data = CMD_O.data;
      end
      if (CMD_O.done === 1'b1) n_done++;
      if (CMD_O.done === 1'b1 && CMD_O.reply === 1'b1) n_reply++;
      if (CMD_O.abort === 1'b1) n_abort++;
   end

   task automatic wrap_up();
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge CLK_SYS_I);
      PSEL_I <= 1'b1;
      PWRITE_I <= wr;
      PADDR_I <= a;
      PWDATA_I <= wd;
      @(posedge CLK_SYS_I);
      PENABLE_I <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK_SYS_I);
         n++;
      end while (PREADY_O !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         wrap_up();
      end else begin
         rd = PRDATA_O;
         err = PSLVERR_O;
         PSEL_I <= 1'b0;
         PENABLE_I <= 1'b0;
      end
   endtask

   // send one frame and judge the pulses that it produced
   task automatic frame(input logic [7:0] q[$], input int ev, ed, er, ea);
      n_valid = 0;
      n_done = 0;
      n_reply = 0;
      n_abort = 0;
      i_host.send_frame(q);
      repeat (8) @(posedge CLK_SYS_I);
      check("valid count", n_valid, ev);
      check("done count", n_done, ed);
      check("reply count", n_reply, er);
      check("abort count", n_abort, ea);
   endtask

   task automatic t_defaults();
      check("default cycles", sacf_pkg::BIT_CYCLES_DEF, 32'd10417);
      check("cfg parity", {SER_CFG_O.par_en, SER_CFG_O.par_odd, SER_CFG_O.data7}, 32'h0);
      check("cfg stops", SER_CFG_O.stop_bit_count, 32'h1);
      check("cfg cycles", SER_CFG_O.bit_cycles, BITC);
      apb(1'b0, sacf_pkg::OFF_CTRL, 32'h0);
      check("ctrl reset", rd, 32'h0);
      apb(1'b0, sacf_pkg::OFF_ADDR, 32'h0);
      check("addr reset", rd, 32'h4);
   endtask

   task automatic t_regs();
      apb(1'b1, sacf_pkg::OFF_ADDR, 32'hf);
      check("addr 15 err", err, 32'h0);
      apb(1'b1, sacf_pkg::OFF_ADDR, 32'h10);
      check("addr 16 err", err, 32'h1);
      apb(1'b0, sacf_pkg::OFF_ADDR, 32'h0);
      check("addr kept", rd, 32'hf);
      apb(1'b1, sacf_pkg::OFF_ADDR, 32'h4);
      apb(1'b1, sacf_pkg::OFF_CTRL, 32'h3);
      check("mode 3 err", err, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped err", err, 32'h1);
      apb(1'b1, sacf_pkg::OFF_STATUS, 32'h0);
      check("status write err", err, 32'h1);
      apb(1'b0, sacf_pkg::OFF_BAUD, 32'h0);
      check("baud reset", rd, {16'h0000, BITC});
      apb(1'b1, sacf_pkg::OFF_BAUD, 32'hf);
      check("baud low err", err, 32'h1);
      apb(1'b1, sacf_pkg::OFF_BAUD, 32'h10);
      check("baud ok err", err, 32'h0);
   endtask

   task automatic t_off();
      frame('{8'h41, 8'h3f, 8'h0a}, 2, 1, 1, 0);
      frame('{8'h41, 8'h0a}, 1, 1, 0, 0);
   endtask

   // framing error mid command: command dropped, rest skipped up to the line feed
   task automatic t_break();
      frame('{8'h41}, 1, 0, 0, 0);
      i_host.send_break();
      repeat (8) @(posedge CLK_SYS_I);
      check("break abort", n_abort, 32'h1);
      frame('{8'h42, 8'h0a}, 0, 0, 0, 0);
   endtask

   task automatic t_addr();
      apb(1'b1, sacf_pkg::OFF_CTRL, 32'h1);
      frame('{8'h30, 8'h34, 8'h3f, 8'h0a}, 1, 1, 1, 0);
      check("forwarded byte", last_data, 32'h3f);
      frame('{8'h30, 8'h34, 8'h41, 8'h0a}, 1, 1, 0, 0);
      frame('{8'h30, 8'h35, 8'h3f, 8'h0a}, 0, 0, 0, 0);
      // two-digit address exercises the tens character of the prefix
      apb(1'b1, sacf_pkg::OFF_ADDR, 32'hc);
      frame('{8'h31, 8'h32, 8'h3f, 8'h0a}, 1, 1, 1, 0);
      apb(1'b1, sacf_pkg::OFF_ADDR, 32'h4);
   endtask

   task automatic t_pkt();
      apb(1'b1, sacf_pkg::OFF_CTRL, 32'h2);
      frame('{8'h02, 8'h04, 8'h41, 8'h03, 8'h46}, 1, 1, 1, 0);
      frame('{8'h02, 8'h05, 8'h3f, 8'h03, 8'h39}, 0, 0, 0, 0);
      frame('{8'h02, 8'h04, 8'h41, 8'h03, 8'h47}, 1, 0, 0, 1);
      apb(1'b0, sacf_pkg::OFF_STATUS, 32'h0);
      check("drop count", rd[15:8], 32'h1);
      check("parser idle", rd[2:0], 32'h0);
      frame('{8'h02, 8'h04, 8'h41, 8'h02, 8'h04, 8'h42, 8'h03, 8'h45}, 2, 1, 1, 1);
      check("restart msg", last_data, 32'h42);
   endtask

   // parity, seven bits and two stops, odd then even
   task automatic t_format();
      logic [31:0] ctl[2] = '{32'h3c, 32'h34};
      foreach (ctl[i]) begin
         apb(1'b1, sacf_pkg::OFF_CTRL, ctl[i]);
         repeat (2) @(posedge CLK_SYS_I);
         check("cfg par_en", SER_CFG_O.par_en, 32'h1);
         check("cfg par_odd", SER_CFG_O.par_odd, ctl[i][3]);
         check("cfg data7", SER_CFG_O.data7, 32'h1);
         check("cfg stops", SER_CFG_O.stop_bit_count, 32'h2);
         frame('{8'h3f, 8'h0a}, 1, 1, 1, 0);
      end
      apb(1'b1, sacf_pkg::OFF_CTRL, 32'h0);
   endtask

   // a hang anywhere ends in the same report
   initial begin
      repeat (100000) @(posedge CLK_SYS_I);
      n_errors++;
      wrap_up();
   end

   initial begin
      RST_I = 1'b1;
      PSEL_I = 1'b0;
      PENABLE_I = 1'b0;
      PWRITE_I = 1'b0;
      PADDR_I = 12'h000;
      PWDATA_I = 32'h0;
      repeat (8) @(posedge CLK_SYS_I);
      RST_I <= 1'b0;
      @(posedge CLK_SYS_I);
      t_defaults();
      t_regs();
      t_off();
      t_break();
      t_format();
      t_addr();
      t_pkt();
      wrap_up();
   end
endmodule // serial_addressed_command_frontend_bench
